// ### shared/bpio_regs.svh
// constants for the parallel io coupling card and its processor end
`ifndef BPIO_REGS_SVH
`define BPIO_REGS_SVH
// ----------------------------------------
// address layout
// ----------------------------------------
`define BPIO_ADDR_W 14
`define BPIO_CHAN_LSB 0
`define BPIO_CHAN_MSB 7
`define BPIO_GRP_LSB 9
`define BPIO_GRP_MSB 11
`define BPIO_OUT_LSB 9
`define BPIO_OUT_MSB 13
`define BPIO_HI_LSB 12
`define BPIO_HI_MSB 13
`define BPIO_HI_INPUT 2'h0
`define BPIO_MASK_OUT_ADDR 5'h17
`define BPIO_CARD_GROUP 3'h0
// ----------------------------------------
// card geometry
// ----------------------------------------
`define BPIO_BYTE_W 8
`define BPIO_IN_BYTES 4
`define BPIO_OUT_BYTES 4
`define BPIO_PINS 32
`define BPIO_OUT_RESET 8'hFF
// ----------------------------------------
// timing
// ----------------------------------------
`define BPIO_WAIT_MAX 6'h3F
`endif

// ### shared/bpio_pkg.sv
// types used by the processor end of the parallel io coupling
package bpio_pkg;
   typedef enum logic [4:0] {
      BPIO_IDLE = 5'h01,
      BPIO_ADDR = 5'h02,
      BPIO_WAIT = 5'h04,
      BPIO_XCHG = 5'h08,
      BPIO_END  = 5'h10
   } bpio_host_state_t;
endpackage

// ### shared/bpio_bus_if.sv
// backplane signals between processor end and coupling card
`timescale 1ns/10ps
interface bpio_bus_if (
   input wire logic sys_clk,
   input wire logic reset
);
   logic [13:0] addr;
   logic cyc_in;
   logic cyc_out;
   logic xchg;
   logic [7:0] write_data;
   logic [7:0] rd_o;
   logic rd_oe_n;
   logic ack_o;
   logic ack_oe_n;
   logic rdy_o;
   logic rdy_oe_n;
   logic irq_o;
   logic irq_oe_n;
   logic int_recognize;
   // open-collector lines with pull-up: low only where some end pulls
   logic [7:0] read_data_lines;
   logic transfer_acknowledge_n;
   logic ready_n;
   logic interrupt_request_n;
   assign read_data_lines = rd_oe_n ? 8'hFF : rd_o;
   assign transfer_acknowledge_n = ack_oe_n ? 1'b1 : ack_o;
   assign ready_n = rdy_oe_n ? 1'b1 : rdy_o;
   assign interrupt_request_n = irq_oe_n ? 1'b1 : irq_o;
   modport dev (
      input sys_clk, reset, addr, cyc_in, cyc_out, xchg, write_data, int_recognize,
      output rd_o, rd_oe_n, ack_o, ack_oe_n, rdy_o, rdy_oe_n, irq_o, irq_oe_n
   );
   modport host (
      input sys_clk, reset, read_data_lines, transfer_acknowledge_n, ready_n, interrupt_request_n,
      output addr, cyc_in, cyc_out, xchg, write_data, int_recognize
   );
endinterface

// ### design/bpio_card.sv
// coupling card: four input bytes, four output bytes, one interrupt flag
`timescale 1ns/10ps
`include "bpio_regs.svh"

// Summary of operation
// RL1 - accumulator one drives output wire low
// RL2 - low input wire reads as one
// RL3 - every channel is eight parallel wires
// RL4 - outputs from write lines, inputs to read lines
// RL5 - eight input groups, twenty-four output bytes
// RL6 - never claim output byte twenty-three
// RL7 - channel number comes from precharged accumulator
// RL8 - input: group bits 9-11, channel 0-7
// RL9 - output: byte bits 9-13, never 00 top
// RL10 - input matches group and channel, output one
// RL11 - acknowledge low on accept or latch
// RL12 - input byte driven during third exchange state
// RL13 - one output moves whole accumulator byte
// RL14 - processor loads channel, then issues input
// RL15 - four input bytes and four output bytes
// RL16 - at most two such cards per system
// RL17 - inputs answer only in group zero
// RL18 - one jumper picks channels 0-3 or 4-7
// RL19 - output jumpers never set top bits 00
// RL20 - avoid group zero as stack channel
// RL21 - addressed card pulls ready low
// RL22 - interrupt held in flag, cleared on recognition
// RL23 - output byte holds until next write
module bpio_card (
   bpio_bus_if.dev bus,
   input wire logic [31:0] in_pins,
   output logic [31:0] out_pins,
   input wire logic irq_pin_n,
   input wire logic input_select_jumpers,
   input wire logic [2:0] group_select_jumpers,
   input wire logic [2:0] output_select_jumpers
);
   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // RL8 input decode, group and channel fields
   function automatic logic in_match(input logic [13:0] a, input logic jsel, input logic [2:0] jgrp);
      logic hit;
      hit = 1'b0;
      // RL18 bit two picks the channel block
      // RL17 only group zero is ever claimed
      if (a[`BPIO_HI_MSB:`BPIO_HI_LSB] == `BPIO_HI_INPUT &&
          a[`BPIO_GRP_MSB:`BPIO_GRP_LSB] == jgrp && jgrp == `BPIO_CARD_GROUP &&
          a[`BPIO_CHAN_MSB:3] == 5'h00 && a[2] == jsel) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // RL9 output decode, byte number in bits 9-13
   function automatic logic out_match(input logic [13:0] a, input logic [2:0] jout);
      logic hit;
      hit = 1'b0;
      // RL6 the interrupt mask byte is left to the processor
      if (a[`BPIO_OUT_MSB:11] == jout && jout[2:1] != `BPIO_HI_INPUT &&
          a[`BPIO_OUT_MSB:`BPIO_OUT_LSB] != `BPIO_MASK_OUT_ADDR) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   logic in_hit;
   logic out_hit;
   logic [1:0] in_byte;
   logic [1:0] out_byte;
   // RL10 input compares group and channel jumpers
   assign in_hit = bus.cyc_in && in_match(bus.addr, input_select_jumpers, group_select_jumpers);
   // RL10 output compares one jumper set
   assign out_hit = bus.cyc_out && out_match(bus.addr, output_select_jumpers);
   // RL7 low channel bits pick one of the four bytes
   assign in_byte = bus.addr[1:0];
   assign out_byte = bus.addr[`BPIO_OUT_LSB+1:`BPIO_OUT_LSB];

   // ----------------------------------------
   // input pin synchronisers
   // ----------------------------------------
   logic [31:0] in_s1_r;
   logic [31:0] in_s2_r;
   logic [31:0] in_s3_r;
   logic [31:0] in_filt_r;
   logic [31:0] in_filt_nxt;

   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         in_s1_r <= 32'hFFFFFFFF;
         in_s2_r <= 32'hFFFFFFFF;
         in_s3_r <= 32'hFFFFFFFF;
      end else begin
         in_s1_r <= in_pins;
         in_s2_r <= in_s1_r;
         in_s3_r <= in_s2_r;
      end
   end

   // a bit only moves once two stages agree, so a runt edge is ignored
   assign in_filt_nxt = (in_s2_r & ~(in_s2_r ^ in_s3_r)) | (in_filt_r & (in_s2_r ^ in_s3_r));

   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         in_filt_r <= 32'hFFFFFFFF;
      end else begin
         in_filt_r <= in_filt_nxt;
      end
   end

   // ----------------------------------------
   // transfer tracking
   // ----------------------------------------
   logic done_r;
   logic ack_r;
   logic sel_in_r;
   logic [7:0] rd_r;

   // one acceptance per bus cycle; cleared as soon as the cycle drops
   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         done_r <= 1'b0;
      end else if (!bus.cyc_in && !bus.cyc_out) begin
         done_r <= 1'b0;
      end else if (in_hit || out_hit) begin
         done_r <= 1'b1;
      end
   end

   // RL11 acknowledge once input taken or output latched
   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         ack_r <= 1'b0;
      end else if (!bus.cyc_in && !bus.cyc_out) begin
         ack_r <= 1'b0;
      end else if ((in_hit || out_hit) && !done_r) begin
         ack_r <= 1'b1;
      end
   end

   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         sel_in_r <= 1'b0;
      end else begin
         sel_in_r <= in_hit;
      end
   end

   // ----------------------------------------
   // input path
   // ----------------------------------------
   // RL2 low wire becomes one on the read lines
   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         rd_r <= 8'h00;
      end else if (in_hit && !done_r) begin
         rd_r <= ~in_filt_r[in_byte*`BPIO_BYTE_W +: `BPIO_BYTE_W];
      end
   end

   // RL12 drive all eight bits in the exchange state
   assign bus.rd_oe_n = !(sel_in_r && in_hit && bus.xchg);
   // RL4 read lines are active low, so a one pulls low
   assign bus.rd_o = ~rd_r;

   // ----------------------------------------
   // output path
   // ----------------------------------------
   // RL15 four output bytes, one latch each
   // RL3 every byte is eight wires
   genvar g;
   generate
      for (g = 0; g < `BPIO_OUT_BYTES; g++) begin : g_out
         // RL13 whole accumulator byte in one transfer
         always_ff @(posedge bus.sys_clk) begin
            if (bus.reset) begin
               out_pins[g*`BPIO_BYTE_W +: `BPIO_BYTE_W] <= `BPIO_OUT_RESET;
            end else if (out_hit && !done_r && out_byte == g) begin
               // RL1 a one bit drives the wire low
               out_pins[g*`BPIO_BYTE_W +: `BPIO_BYTE_W] <= ~bus.write_data;
            end
            // RL23 otherwise the byte holds its last value
         end
      end
   endgenerate

   // ----------------------------------------
   // handshake lines
   // ----------------------------------------
   // RL21 ready pulled low while the card is addressed
   assign bus.rdy_oe_n = !(in_hit || out_hit);
   assign bus.rdy_o = 1'b0;
   assign bus.ack_oe_n = !ack_r;
   assign bus.ack_o = 1'b0;

   // ----------------------------------------
   // interrupt flag
   // ----------------------------------------
   logic irq_s1_r;
   logic irq_s2_r;
   logic irq_s3_r;
   logic irq_lvl_r;
   logic irq_flag_r;
   logic irq_fall;

   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         irq_s1_r <= 1'b1;
         irq_s2_r <= 1'b1;
         irq_s3_r <= 1'b1;
      end else begin
         irq_s1_r <= irq_pin_n;
         irq_s2_r <= irq_s1_r;
         irq_s3_r <= irq_s2_r;
      end
   end

   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         irq_lvl_r <= 1'b1;
      end else if (irq_s2_r == irq_s3_r) begin
         irq_lvl_r <= irq_s3_r;
      end
   end

   assign irq_fall = irq_lvl_r && irq_s2_r == irq_s3_r && !irq_s3_r;

   // RL22 flag holds request, recognition clears, new request wins
   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         irq_flag_r <= 1'b0;
      end else if (irq_fall) begin
         irq_flag_r <= 1'b1;
      end else if (bus.int_recognize) begin
         irq_flag_r <= 1'b0;
      end
   end

   assign bus.irq_oe_n = !irq_flag_r;
   assign bus.irq_o = 1'b0;
endmodule

// ### design/bpio_host.sv
// processor end: runs input and output cycles on the backplane
`timescale 1ns/10ps
`include "bpio_regs.svh"

module bpio_host (
   bpio_bus_if.host bus,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_out,
   input wire logic [4:0] req_unit,
   input wire logic [7:0] req_acc,
   output logic done,
   output logic [7:0] rsp_acc,
   output logic rsp_ack,
   output logic rsp_err,
   output logic irq_pending,
   input wire logic irq_recognize
);
   // ----------------------------------------
   // cycle sequencer
   // ----------------------------------------
   bpio_pkg::bpio_host_state_t state_r;
   logic [5:0] wait_cnt_r;
   logic out_r;
   logic bad_req;

   // RL19 top byte bits 00 never reach an output card
   assign bad_req = req_out && req_unit[4:3] == `BPIO_HI_INPUT;
   assign req_ready = state_r == bpio_pkg::BPIO_IDLE;

   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         state_r <= bpio_pkg::BPIO_IDLE;
      end else begin
         case (state_r)
            bpio_pkg::BPIO_IDLE: begin
               if (req_valid && !bad_req) begin
                  state_r <= bpio_pkg::BPIO_ADDR;
               end
            end
            bpio_pkg::BPIO_ADDR: state_r <= bpio_pkg::BPIO_WAIT;
            bpio_pkg::BPIO_WAIT: begin
               // RL21 wait states until ready or give up
               if (!bus.ready_n || wait_cnt_r == `BPIO_WAIT_MAX) begin
                  state_r <= bpio_pkg::BPIO_XCHG;
               end
            end
            bpio_pkg::BPIO_XCHG: state_r <= bpio_pkg::BPIO_END;
            bpio_pkg::BPIO_END: state_r <= bpio_pkg::BPIO_IDLE;
            default: state_r <= bpio_pkg::BPIO_IDLE;
         endcase
      end
   end

   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset || state_r != bpio_pkg::BPIO_WAIT) begin
         wait_cnt_r <= 6'h00;
      end else begin
         wait_cnt_r <= wait_cnt_r + 6'h01;
      end
   end

   // ----------------------------------------
   // bus drive
   // ----------------------------------------
   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         bus.addr <= 14'h0000;
         bus.write_data <= 8'h00;
         out_r <= 1'b0;
      end else if (req_ready && req_valid && !bad_req) begin
         out_r <= req_out;
         bus.write_data <= req_acc;
         if (req_out) begin
            // RL13 accumulator goes out whole with the byte number
            bus.addr <= {req_unit, 9'h000};
         end else begin
            // RL14 channel from accumulator, group from instruction
            bus.addr <= {2'h0, req_unit[2:0], 1'b0, req_acc};
         end
      end
   end

   // RL5 cycle type marks input or output space
   assign bus.cyc_in = !out_r && state_r != bpio_pkg::BPIO_IDLE && state_r != bpio_pkg::BPIO_END;
   assign bus.cyc_out = out_r && state_r != bpio_pkg::BPIO_IDLE && state_r != bpio_pkg::BPIO_END;
   assign bus.xchg = state_r == bpio_pkg::BPIO_XCHG;
   assign bus.int_recognize = irq_recognize;
   assign irq_pending = !bus.interrupt_request_n;

   // ----------------------------------------
   // result
   // ----------------------------------------
   always_ff @(posedge bus.sys_clk) begin
      if (bus.reset) begin
         done <= 1'b0;
         rsp_acc <= 8'h00;
         rsp_ack <= 1'b0;
         rsp_err <= 1'b0;
      end else begin
         done <= state_r == bpio_pkg::BPIO_XCHG || (req_ready && req_valid && bad_req);
         if (state_r == bpio_pkg::BPIO_XCHG) begin
            // RL12 data taken in the exchange state, lines active low
            rsp_acc <= out_r ? 8'h00 : ~bus.read_data_lines;
            rsp_ack <= !bus.transfer_acknowledge_n;
            rsp_err <= bus.ready_n;
         end else if (req_ready && req_valid && bad_req) begin
            rsp_acc <= 8'h00;
            rsp_ack <= 1'b0;
            rsp_err <= 1'b1;
         end
      end
   end
endmodule

// ### sim/bpio_props.sv
// concurrent checks on the backplane between processor end and card
`timescale 1ns/10ps
module bpio_props (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [13:0] addr,
   input wire logic cyc_in,
   input wire logic cyc_out,
   input wire logic xchg,
   input wire logic [7:0] read_data_lines,
   input wire logic transfer_acknowledge_n,
   input wire logic ready_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // ----------------------------------------
   // transfer steps
   // ----------------------------------------
   sequence s_claim;
      (cyc_in || cyc_out) && !ready_n;
   endsequence
   sequence s_start;
      $rose(cyc_in || cyc_out) && !ready_n;
   endsequence
   sequence s_finish;
      ##2 xchg ##1 !(cyc_in || cyc_out);
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_NO_WAIT: assert property (s_start |-> s_finish)
      else $error("claimed cycle did not finish without waits");
   AST_ACK_NEXT: assert property (s_claim |=> !transfer_acknowledge_n)
      else $error("no acknowledge after claim");
   AST_ACK_IDLE: assert property (!(cyc_in || cyc_out) && $past(!(cyc_in || cyc_out)) |-> transfer_acknowledge_n)
      else $error("acknowledge held outside a cycle");
   AST_MASK_BYTE: assert property (cyc_out && addr[13:9] == 5'h17 |-> ready_n)
      else $error("mask output byte claimed");
   AST_GROUP: assert property (cyc_in && addr[11:9] != 3'h0 |-> ready_n)
      else $error("input claimed outside group zero");
   AST_CHAN: assert property (cyc_in && addr[7:3] != 5'h00 |-> ready_n)
      else $error("input claimed above channel seven");
   AST_DATA_XCHG: assert property (read_data_lines != 8'hFF |-> xchg && cyc_in)
      else $error("read lines driven outside exchange");
   AST_IDLE_RDY: assert property (!(cyc_in || cyc_out) |-> ready_n && read_data_lines == 8'hFF)
      else $error("lines pulled while no cycle runs");
endmodule

// ### sim/test_bus_parallel_io_coupling.sv
// self-checking bench joining processor end and coupling card
`timescale 1ns/10ps
module test_bus_parallel_io_coupling;
   logic sys_clk;
   logic reset;
   logic req_valid;
   logic req_ready;
   logic req_out;
   logic [4:0] req_unit;
   logic [7:0] req_acc;
   logic done;
   logic [7:0] rsp_acc;
   logic rsp_ack;
   logic rsp_err;
   logic irq_pending;
   logic irq_recognize;
   logic [31:0] in_pins;
   logic [31:0] out_pins;
   logic irq_pin_n;
   logic input_select_jumpers;
   logic [2:0] group_select_jumpers;
   logic [2:0] output_select_jumpers;
   int mismatches;
   int n_tests;
   int lat_cycles;
   // ----------------------------------------
   // instances
   // ----------------------------------------
   bpio_bus_if bus (.sys_clk(sys_clk), .reset(reset));
   bpio_card i_bpio_card (.bus(bus), .in_pins(in_pins), .out_pins(out_pins), .irq_pin_n(irq_pin_n),
      .input_select_jumpers(input_select_jumpers), .group_select_jumpers(group_select_jumpers),
      .output_select_jumpers(output_select_jumpers));
   bpio_host i_bpio_host (.bus(bus), .req_valid(req_valid), .req_ready(req_ready), .req_out(req_out),
      .req_unit(req_unit), .req_acc(req_acc), .done(done), .rsp_acc(rsp_acc), .rsp_ack(rsp_ack),
      .rsp_err(rsp_err), .irq_pending(irq_pending), .irq_recognize(irq_recognize));
   bpio_props i_bpio_props (.sys_clk(sys_clk), .reset(reset), .addr(bus.addr), .cyc_in(bus.cyc_in),
      .cyc_out(bus.cyc_out), .xchg(bus.xchg), .read_data_lines(bus.read_data_lines),
      .transfer_acknowledge_n(bus.transfer_acknowledge_n), .ready_n(bus.ready_n));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until the edge that takes it; bound covers the 63-wait timeout
   task automatic xfer(input logic o, input logic [4:0] u, input logic [7:0] a);
      int k;
      @(posedge sys_clk);
      #1;
      req_out = o;
      req_unit = u;
      req_acc = a;
      req_valid = 1'b1;
      k = 0;
      while (req_ready !== 1'b1 && k < 10) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      if (k == 10) begin
         chk(req_ready, 1'b1);
         tally_and_finish();
      end
      @(posedge sys_clk);
      #1;
      req_valid = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 100) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      if (k == 100) begin
         chk(done, 1'b1);
         tally_and_finish();
      end
      lat_cycles = k;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic sc_out;
      logic [31:0] exp;
      logic [7:0] d;
      exp = 32'hFFFF_FFFF;
      output_select_jumpers = 3'h2;
      for (int k = 0; k < 4; k++) begin
         d = 8'hA0 + 8'(k);
         xfer(1'b1, {3'h2, 2'(k)}, d);
         exp[8*k +: 8] = ~d;
         chk(rsp_ack, 1'b1);
         chk(lat_cycles, 32'h3);
         chk(out_pins, exp);
      end
      xfer(1'b1, 5'h0C, 8'h55);
      chk({rsp_ack, rsp_err}, 2'h1);
      chk(lat_cycles, 32'h42);
      chk(out_pins, exp);
      output_select_jumpers = 3'h5;
      xfer(1'b1, 5'h17, 8'hFF);
      chk({rsp_ack, rsp_err}, 2'h1);
      xfer(1'b1, 5'h14, 8'h0F);
      exp[7:0] = 8'hF0;
      chk(out_pins, exp);
      xfer(1'b1, 5'h03, 8'h00);
      chk({rsp_ack, rsp_err}, 2'h1);
      chk(lat_cycles, 32'h0);
      chk(out_pins, exp);
   endtask
   task automatic sc_in;
      logic [31:0] pins;
      pins = 32'h3CA5_0F81;
      in_pins = pins;
      repeat (4) @(posedge sys_clk);
      #1;
      for (int j = 0; j < 2; j++) begin
         input_select_jumpers = j[0];
         for (int k = 0; k < 4; k++) begin
            xfer(1'b0, 5'h00, 8'(4 * j + k));
            chk(rsp_acc, 8'(~pins[8*k +: 8]));
         end
         xfer(1'b0, 5'h00, 8'(4 - 4 * j));
         chk({rsp_ack, rsp_err}, 2'h1);
      end
      // channel twelve shares bit two and the byte bits with channel four
      xfer(1'b0, 5'h00, 8'h0C);
      chk({rsp_ack, rsp_err}, 2'h1);
      xfer(1'b0, 5'h01, 8'h04);
      chk({rsp_ack, rsp_err}, 2'h1);
      group_select_jumpers = 3'h1;
      xfer(1'b0, 5'h00, 8'h04);
      chk({rsp_ack, rsp_err}, 2'h1);
      group_select_jumpers = 3'h0;
   endtask
   task automatic sc_reset;
      reset = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      chk(out_pins, 32'hFFFF_FFFF);
      chk(req_ready, 1'b1);
   endtask
   task automatic sc_irq;
      irq_pin_n = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
      chk(irq_pending, 1'b1);
      irq_pin_n = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk(irq_pending, 1'b1);
      irq_recognize = 1'b1;
      @(posedge sys_clk);
      #1;
      irq_recognize = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk(irq_pending, 1'b0);
      // a fresh request landing on the recognition cycle must survive
      irq_pin_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      irq_recognize = 1'b1;
      @(posedge sys_clk);
      #1;
      irq_recognize = 1'b0;
      chk(irq_pending, 1'b1);
      irq_pin_n = 1'b1;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      mismatches = 0;
      n_tests = 0;
      reset = 1'b1;
      req_valid = 1'b0;
      req_out = 1'b0;
      req_unit = 5'h00;
      req_acc = 8'h00;
      irq_recognize = 1'b0;
      in_pins = 32'hFFFF_FFFF;
      irq_pin_n = 1'b1;
      input_select_jumpers = 1'b0;
      group_select_jumpers = 3'h0;
      output_select_jumpers = 3'h0;
      repeat (12) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      chk(out_pins, 32'hFFFF_FFFF);
      sc_out();
      sc_reset();
      sc_in();
      sc_irq();
      tally_and_finish();
   end
endmodule
